/* design/mtpm_fifo.sv */
// Word FIFO with a registered output stage
`timescale 1ns/1ps
module mtpm_fifo #(
   parameter int W = 14,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_idx;
   logic [AW-1:0] rd_idx;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign in_ready = count != FULL;
   assign push = in_valid && in_ready;
   // Output stage refills whenever it is empty or being drained
   assign pop = (count != '0) && (!out_valid || out_ready);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         wr_idx <= '0;
         rd_idx <= '0;
         count <= '0;
         out_valid <= 1'b0;
         out_data <= '0;
      end else begin
         if (push) begin
            mem[wr_idx] <= in_data;
            wr_idx <= (wr_idx == LAST) ? '0 : wr_idx + 1'b1;
         end
         if (pop) begin
            out_data <= mem[rd_idx];
            rd_idx <= (rd_idx == LAST) ? '0 : rd_idx + 1'b1;
         end
         if (pop) begin
            out_valid <= 1'b1;
         end else if (out_ready) begin
            out_valid <= 1'b0;
         end
         count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end
endmodule

/* design/mtpm_pkg.sv */
// Package: shared constants and types of the MAC transmit pin mode mux
// Overview of operation
// [RULE1] RGMII: four data pins carry a nibble, index order, taken on the transmit clock
// [RULE2] RGMII: the control pin qualifies each nibble, taken on the same clock edge
// [RULE3] RMII: only data bits 0 and 1 carry data, taken on the reference clock
// [RULE4] RMII: transmit enable, active high, marks valid dibits
// [RULE5] RMII: data pin 2 is unused; the MAC holds it low
// [RULE6] RTBI: rising edge carries the low bit of each pin, falling edge the high bit
// [RULE7] RTBI: data pin 0 carries code bits 0 and 5
// [RULE8] RTBI: data pin 1 carries code bits 1 and 6
// [RULE9] RTBI: data pin 2 carries code bits 2 and 7
// [RULE10] RTBI: control pin becomes data, carrying code bits 4 and 9
// [RULE11] SGMII: device drives a serial output pair with its own serial clock pair
// [RULE12] SGMII: device takes a serial input pair and recovers its clock itself
// [RULE13] 1000BASE-X: device sends serial data on the SGMII output pair
// [RULE14] 1000BASE-X: device takes serial data on the SGMII input pair
// [RULE15] RGMII: MAC supplies a continuous transmit clock at the speed's rate; the bench's MAC model pulses it once per word and holds it low otherwise
// [RULE16] RMII: one shared reference clock times both directions
// [RULE17] RTBI: data pin 3 carries code bits 3 and 8
// [RULE18] Exactly one mode at a time; shared pins read only by that mode
package mtpm_pkg;

   localparam logic [2:0] MODE_RGMII = 3'h0;
   localparam logic [2:0] MODE_RMII = 3'h1;
   localparam logic [2:0] MODE_RTBI = 3'h2;
   localparam logic [2:0] MODE_SGMII = 3'h3;
   localparam logic [2:0] MODE_BASEX = 3'h4;
   localparam logic [2:0] MODE_NONE = 3'h7;

   localparam int REF_CLK_PERIOD_NS = 100;
   localparam int SERIAL_RATE_MBPS = 1250;
   localparam int SERIAL_CLK_MHZ = 625;
   localparam int BITS_PER_SERIAL_CLK = SERIAL_RATE_MBPS / SERIAL_CLK_MHZ;
   localparam int SER_DIV_DEFAULT = 4;
   localparam int FIFO_DEPTH_DEFAULT = 8;
   localparam logic [1:0] SETTLE_LAST = 2'h3;
   localparam int TENBIT_HALF = 5;
   localparam logic [3:0] TENBIT_LAST = 4'h9;
   localparam logic [9:0] SER_IDLE_CODE = 10'h283;
   localparam logic [3:0] SERIAL_DATA_PINS = 4'h6;
   localparam logic [3:0] SERIAL_CLK_PIN = 4'h8;

   typedef enum logic {MS_SETTLE, MS_RUN} mtpm_mstate_type;

   typedef struct packed {
      logic [9:0] data;
      logic ctl;
      logic [2:0] mode;
   } mtpm_word_type;

   typedef struct packed {
      logic clk;
      logic [3:0] txd;
      logic ctl;
      logic [2:0] mode;
   } mtpm_pins_type;

   typedef struct packed {
      mtpm_mstate_type fsm;
      logic [2:0] mode;
      logic [1:0] settle;
      logic clk_prev;
      logic rtbi_lo_ok;
      logic [4:0] rtbi_lo;
      logic push;
      mtpm_word_type word;
      logic overrun;
      logic sin_prev;
      logic [7:0] sin_phase;
      logic [3:0] sin_cnt;
      logic [9:0] sin_shift;
      logic [7:0] so_phase;
      logic [3:0] so_cnt;
      logic [9:0] so_shift;
      logic [9:0] so_next;
      logic so_have;
      logic so_ready;
      logic so_clk;
      logic so_bit;
      logic clk_drv;
      logic clk_oe;
      logic [3:0] txd_drv;
      logic [3:0] txd_oe;
   } mtpm_state_type;

   localparam mtpm_state_type ST_RESET = '{fsm: MS_SETTLE, mode: MODE_NONE, so_shift: SER_IDLE_CODE,
                                           so_ready: 1'b1, default: '0};

endpackage

/* design/mtpm_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module mtpm_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Data
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [1:0][W-1:0] stage;
   logic [1:0][W-1:0] next_stage;

   always_comb begin
      next_stage[0] = async_in;
      next_stage[1] = stage[0];
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         stage <= '0;
      end else begin
         stage <= next_stage;
      end
   end

   assign sync_out = stage[1];
endmodule

/* design/mtpm_top.sv */
// Mode-dependent capture and drive of the MAC-facing transmit-side pins
`timescale 1ns/1ps
module mtpm_top
   import mtpm_pkg::*;
#(
   parameter int SER_DIV = SER_DIV_DEFAULT,
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEFAULT
) (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RSTN,
   // Interface mode strap
   input wire logic [2:0] MODE,
   // Shared transmit-side pins
   input wire logic TX_CLK_IN,
   output logic TX_CLK_OUT,
   output logic TX_CLK_OE,
   input wire logic [3:0] TXD_IN,
   output logic [3:0] TXD_OUT,
   output logic [3:0] TXD_OE,
   input wire logic TX_CTL_IN,
   // Captured transmit words
   output logic TXW_VALID,
   input wire logic TXW_READY,
   output mtpm_word_type TXW_DATA,
   output logic LINK_OVERRUN,
   // Code groups for the serial output
   input wire logic SO_VALID,
   input wire logic [9:0] SO_DATA,
   output logic SO_READY
);
   localparam logic [7:0] PHASE_LAST = 8'(SER_DIV - 1);
   localparam logic [7:0] PHASE_MID = 8'(SER_DIV / 2);

   mtpm_state_type st;
   mtpm_state_type next_st;
   mtpm_pins_type pin_raw;
   mtpm_pins_type pin_s;
   logic rise;
   logic fall;
   logic sin_bit;
   logic run_serial;
   logic fifo_in_ready;

   function automatic logic is_serial(input logic [2:0] mode);
      is_serial = (mode == MODE_SGMII) || (mode == MODE_BASEX);
   endfunction

   // One half of a ten-bit code group, one bit per pin, control pin on top
   function automatic logic [4:0] tenbit_half(input mtpm_pins_type p);
      tenbit_half = {p.ctl, p.txd};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   assign pin_raw = '{clk: TX_CLK_IN, txd: TXD_IN, ctl: TX_CTL_IN, mode: MODE};

   mtpm_sync #(
      .W($bits(mtpm_pins_type))
   ) u_sync (
      .clk(REF_CLK),
      .rstn(RSTN),
      .async_in(pin_raw),
      .sync_out(pin_s)
   );

   // Link clock edges seen by oversampling; the MAC's clock must stay slow
   assign rise = pin_s.clk && !st.clk_prev; // RULE15
   assign fall = !pin_s.clk && st.clk_prev;
   // A pair at equal levels carries no bit, so the last bit is held
   assign sin_bit = (pin_s.txd[0] != pin_s.ctl) ? pin_s.txd[0] : st.sin_prev;
   assign run_serial = (st.fsm == MS_RUN) && is_serial(st.mode);

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      next_st = st;
      next_st.clk_prev = pin_s.clk;
      next_st.sin_prev = sin_bit;
      next_st.push = 1'b0;
      // Link words cannot be held back, so a full FIFO loses them
      if (st.push && !fifo_in_ready) begin
         next_st.overrun = 1'b1;
      end
      case (st.fsm)
         MS_SETTLE: begin
            if (st.settle == SETTLE_LAST) begin
               next_st.fsm = MS_RUN;
            end else begin
               next_st.settle = st.settle + 2'h1;
            end
         end
         MS_RUN: begin
            case (st.mode)
               MODE_RGMII: begin
                  if (rise) begin
                     next_st.push = 1'b1; // RULE1
                     next_st.word = '{data: {6'h00, pin_s.txd}, ctl: pin_s.ctl, mode: st.mode}; // RULE2
                  end
               end
               MODE_RMII: begin
                  // Pins 2 and 3 are ignored in this mode
                  if (rise && pin_s.ctl) begin // RULE4 RULE16
                     next_st.push = 1'b1;
                     next_st.word = '{data: {8'h00, pin_s.txd[1:0]}, ctl: 1'b1, mode: st.mode}; // RULE3 RULE5
                  end
               end
               MODE_RTBI: begin
                  if (rise) begin
                     next_st.rtbi_lo = tenbit_half(pin_s); // RULE6
                     next_st.rtbi_lo_ok = 1'b1;
                  end
                  // A falling edge without its rising half is dropped
                  if (fall && st.rtbi_lo_ok) begin
                     next_st.rtbi_lo_ok = 1'b0;
                     next_st.push = 1'b1;
                     // RULE7 RULE8 RULE9 RULE10 RULE17
                     next_st.word = '{data: {tenbit_half(pin_s), st.rtbi_lo}, ctl: 1'b0, mode: st.mode};
                  end
               end
               MODE_SGMII, MODE_BASEX: begin
                  // Clock recovery: realign the bit phase on each data edge
                  if ((sin_bit != st.sin_prev) || (st.sin_phase == PHASE_LAST)) begin // RULE12
                     next_st.sin_phase = 8'h00;
                  end else begin
                     next_st.sin_phase = st.sin_phase + 8'h01;
                  end
                  if (st.sin_phase == PHASE_MID) begin
                     next_st.sin_shift = {sin_bit, st.sin_shift[9:1]};
                     if (st.sin_cnt == TENBIT_LAST) begin // RULE14
                        next_st.sin_cnt = 4'h0;
                        next_st.push = 1'b1;
                        next_st.word = '{data: {sin_bit, st.sin_shift[9:1]}, ctl: 1'b0, mode: st.mode};
                     end else begin
                        next_st.sin_cnt = st.sin_cnt + 4'h1;
                     end
                  end
                  // Serial output, least significant bit first
                  if (st.so_phase == PHASE_LAST) begin
                     next_st.so_phase = 8'h00;
                     next_st.so_clk = !st.so_clk; // RULE11
                     next_st.so_bit = st.so_shift[0]; // RULE13
                     if (st.so_cnt == TENBIT_LAST) begin
                        next_st.so_cnt = 4'h0;
                        next_st.so_shift = st.so_have ? st.so_next : SER_IDLE_CODE;
                        next_st.so_have = 1'b0;
                     end else begin
                        next_st.so_cnt = st.so_cnt + 4'h1;
                        next_st.so_shift = {1'b0, st.so_shift[9:1]};
                     end
                  end else begin
                     next_st.so_phase = st.so_phase + 8'h01;
                  end
               end
               default: begin
                  next_st.push = 1'b0;
               end
            endcase
         end
         default: begin
            next_st.fsm = MS_SETTLE;
         end
      endcase
      if (SO_VALID && st.so_ready) begin
         next_st.so_have = 1'b1;
         next_st.so_next = SO_DATA;
      end
      next_st.so_ready = !next_st.so_have;
      // A new mode restarts every capture and output path
      if (pin_s.mode != st.mode) begin // RULE18
         next_st.mode = pin_s.mode;
         next_st.fsm = MS_SETTLE;
         next_st.settle = 2'h0;
         next_st.rtbi_lo_ok = 1'b0;
         next_st.sin_cnt = 4'h0;
         next_st.sin_phase = 8'h00;
         next_st.so_cnt = 4'h0;
         next_st.so_phase = 8'h00;
      end
      // Pin drivers; a pin not enabled is driven low
      next_st.txd_oe = run_serial ? SERIAL_DATA_PINS : 4'h0;
      if (run_serial && (st.mode == MODE_SGMII)) begin // RULE11
         next_st.txd_oe = SERIAL_DATA_PINS | SERIAL_CLK_PIN;
      end
      next_st.clk_oe = run_serial && (st.mode == MODE_SGMII);
      next_st.clk_drv = next_st.clk_oe && st.so_clk;
      next_st.txd_drv = {!st.so_clk, st.so_bit, !st.so_bit, 1'b0} & next_st.txd_oe; // RULE13
   end

   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         st <= ST_RESET;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Word FIFO toward the user side

   mtpm_fifo #(
      .W($bits(mtpm_word_type)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(REF_CLK),
      .rstn(RSTN),
      .in_valid(st.push),
      .in_ready(fifo_in_ready),
      .in_data(st.word),
      .out_valid(TXW_VALID),
      .out_ready(TXW_READY),
      .out_data(TXW_DATA)
   );

   assign TX_CLK_OUT = st.clk_drv;
   assign TX_CLK_OE = st.clk_oe;
   assign TXD_OUT = st.txd_drv;
   assign TXD_OE = st.txd_oe;
   assign LINK_OVERRUN = st.overrun;
   assign SO_READY = st.so_ready;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RSTN);

   chk_rgmii_nibble: assert property ( // RULE1
      (st.fsm == MS_RUN && st.mode == MODE_RGMII && pin_s.mode == MODE_RGMII && rise)
      |=> (st.push && st.word.data == {6'h00, $past(pin_s.txd)}))
      else $error("RGMII nibble not captured");

   chk_rgmii_ctl: assert property ( // RULE2
      (st.fsm == MS_RUN && st.mode == MODE_RGMII && rise) |=> (st.word.ctl == $past(pin_s.ctl)))
      else $error("RGMII control not captured with its nibble");

   chk_rmii_enable: assert property ( // RULE4
      (st.fsm == MS_RUN && st.mode == MODE_RMII && !(rise && pin_s.ctl)) |=> !st.push)
      else $error("RMII word pushed without enable");

   chk_rmii_dibit: assert property ( // RULE3
      (st.fsm == MS_RUN && st.mode == MODE_RMII && pin_s.mode == MODE_RMII && rise && pin_s.ctl)
      |=> (st.push && st.word.data == {8'h00, $past(pin_s.txd[1:0])}))
      else $error("RMII dibit wrong");

   chk_rtbi_order: assert property ( // RULE6 RULE7 RULE8 RULE9 RULE10 RULE17
      (st.fsm == MS_RUN && st.mode == MODE_RTBI && pin_s.mode == MODE_RTBI && rise) ##1
      (!fall && !rise && pin_s.mode == MODE_RTBI)[*3] ##1 (fall && st.fsm == MS_RUN)
      |=> (st.push && st.word.data[4:0] == $past(st.rtbi_lo, 1)
           && st.word.data[9:TENBIT_HALF] == {$past(pin_s.ctl), $past(pin_s.txd)}))
      else $error("RTBI code group halves misplaced");

   chk_serial_oe: assert property ( // RULE11 RULE13
      run_serial |=> (TXD_OE == (SERIAL_DATA_PINS | (st.mode == MODE_SGMII ? SERIAL_CLK_PIN : 4'h0))))
      else $error("Serial pins not enabled for the mode");

   chk_serial_pair: assert property ( // RULE11
      (TXD_OE == (SERIAL_DATA_PINS | SERIAL_CLK_PIN)) |-> (TXD_OUT[2] != TXD_OUT[1] && TX_CLK_OUT != TXD_OUT[3]))
      else $error("Serial pairs not complementary");

   chk_serial_clock: assert property ( // RULE11
      (run_serial && st.so_phase == PHASE_LAST && pin_s.mode == st.mode) |=> (st.so_clk != $past(st.so_clk)))
      else $error("Serial clock missed a bit boundary");

   chk_serial_word: assert property ( // RULE12 RULE14
      (run_serial && pin_s.mode == st.mode && st.sin_phase == PHASE_MID && st.sin_cnt == TENBIT_LAST)
      |=> (st.push && st.word.data[9] == $past(sin_bit)))
      else $error("Serial code group not delivered");

   chk_one_mode: assert property ( // RULE18
      !is_serial(st.mode) |=> (TXD_OE == 4'h0 && !TX_CLK_OE))
      else $error("Pins driven outside a serial mode");

   chk_rmii_clock: assert property ( // RULE16
      (st.push && st.word.mode == MODE_RMII) |-> $past(rise))
      else $error("RMII word not tied to the reference clock");

   chk_overrun_sticky: assert property (
      st.overrun |=> st.overrun)
      else $error("Overrun flag cleared");

   ////////////////////////////////////////////////////////////////////////////
   // Capture details per mode, while settling and on overrun

   chk_rmii_upper: assert property ( // RULE3 RULE5
      (st.push && st.word.mode == MODE_RMII) |-> (st.word.data[9:2] == 8'h00 && st.word.ctl))
      else $error("RMII word carries unused pins");

   chk_rtbi_rise_half: assert property ( // RULE6 RULE10
      (st.fsm == MS_RUN && st.mode == MODE_RTBI && pin_s.mode == MODE_RTBI && rise)
      |=> (st.rtbi_lo_ok && st.rtbi_lo == $past({pin_s.ctl, pin_s.txd})))
      else $error("RTBI low half not held");

   // A lone falling edge must not produce a half-filled code group
   chk_rtbi_orphan: assert property ( // RULE6
      (st.fsm == MS_RUN && st.mode == MODE_RTBI && fall && !st.rtbi_lo_ok) |=> !st.push)
      else $error("RTBI word without its low half");

   chk_settle_quiet: assert property ( // RULE18
      (st.fsm == MS_SETTLE) |=> !st.push)
      else $error("Word captured while settling");

   chk_overrun_set: assert property (
      (st.push && !fifo_in_ready) |=> LINK_OVERRUN)
      else $error("Lost word not flagged");

   ////////////////////////////////////////////////////////////////////////////
   // Serial path details

   chk_so_taken: assert property ( // RULE11 RULE13
      (SO_VALID && SO_READY) |=> !SO_READY)
      else $error("Serial holding register not marked full");

   chk_serial_bit: assert property ( // RULE13
      (run_serial && st.so_phase == PHASE_LAST && pin_s.mode == st.mode) |=> (st.so_bit == $past(st.so_shift[0])))
      else $error("Serial bit out of order");

   chk_basex_noclk: assert property ( // RULE13 RULE18
      (st.mode == MODE_BASEX) |=> (!TX_CLK_OE && !TXD_OE[3] && !TXD_OE[0]))
      else $error("Clock pins driven in fibre mode");

   // Bit phase restarts on every data transition of the input pair
   chk_sin_resync: assert property ( // RULE12
      (run_serial && pin_s.mode == st.mode && sin_bit != st.sin_prev) |=> (st.sin_phase == 8'h00))
      else $error("Serial input phase not realigned");
endmodule

/* tb/mtpm_mac_model.sv */
// MAC-side and serial-source model driving the device's transmit-side pins
`timescale 1ns/1ps
module mtpm_mac_model
   import mtpm_pkg::*;
#(
   parameter int SD = 4
) (
   // Clock
   input wire logic ref_clk,
   // Commands from the bench
   input wire logic [2:0] mode,
   input wire logic go,
   input wire logic [4:0] lo,
   input wire logic [4:0] hi,
   input wire logic ser_en,
   input wire logic [9:0] ser_pat,
   // Pins toward the device
   output logic tx_clk,
   output logic [3:0] txd,
   output logic tx_ctl
);
   logic [3:0] cnt = 4'h0;
   logic [7:0] div = 8'h00;
   logic [3:0] idx = 4'h0;

   initial begin
      tx_clk = 1'b0;
      txd = 4'h0;
      tx_ctl = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Link clock stands low outside frames; the model drives data and control pins low from count 10
   always @(posedge ref_clk) begin
      if (ser_en) begin
         div <= (div == 8'(SD - 1)) ? 8'h00 : div + 8'h01;
         if (div == 8'h00) begin
            // No clock is sent: the device must recover it from the data
            txd <= {3'h0, ser_pat[idx]};
            tx_ctl <= ~ser_pat[idx];
            idx <= (idx == 4'h9) ? 4'h0 : idx + 4'h1;
         end
      end else if (go || cnt != 4'h0) begin
         cnt <= (cnt == 4'hC) ? 4'h0 : cnt + 4'h1;
         if (go) begin
            txd <= (mode == MODE_RMII) ? {2'h0, lo[1:0]} : lo[3:0];
            tx_ctl <= lo[4];
         end
         if (cnt == 4'h3) begin
            tx_clk <= 1'b1;
         end
         // High half changes midway so both edges see settled data
         if (cnt == 4'h5 && mode == MODE_RTBI) begin
            txd <= hi[3:0];
            tx_ctl <= hi[4];
         end
         if (cnt == 4'h7) begin
            tx_clk <= 1'b0;
         end
         if (cnt == 4'hA) begin
            txd <= 4'h0;
            tx_ctl <= 1'b0;
         end
      end
   end
endmodule

/* tb/mtpm_top_test.sv */
// Self-checking bench for the transmit pin mode mux
`timescale 1ns/1ps
module mtpm_top_test
   import mtpm_pkg::*;
;
   localparam int SD = 4;
   localparam int LIMIT = 20000;
   localparam logic [9:0] PAT = 10'h00B;

   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic [2:0] mode = MODE_NONE;
   logic tx_clk_in;
   logic tx_clk_out;
   logic tx_clk_oe;
   logic [3:0] txd_in;
   logic [3:0] txd_out;
   logic [3:0] txd_oe;
   logic tx_ctl_in;
   logic txw_valid;
   logic txw_ready = 1'b0;
   mtpm_word_type txw_data;
   logic link_overrun;
   logic so_valid = 1'b0;
   logic [9:0] so_data = 10'h000;
   logic so_ready;
   logic go = 1'b0;
   logic [4:0] m_lo = 5'h00;
   logic [4:0] m_hi = 5'h00;
   logic ser_en = 1'b0;
   logic m_clk;
   logic [3:0] m_txd;
   int num_errors = 0;
   int samples_checked = 0;
   int cyc = 0;

   // Shared pins resolve to whichever party enables its driver
   assign tx_clk_in = tx_clk_oe ? tx_clk_out : m_clk;
   assign txd_in = (txd_oe & txd_out) | (~txd_oe & m_txd);

   mtpm_top #(.SER_DIV(SD), .FIFO_DEPTH(8)) u_dut (
      .REF_CLK(ref_clk), .RSTN(rstn), .MODE(mode),
      .TX_CLK_IN(tx_clk_in), .TX_CLK_OUT(tx_clk_out), .TX_CLK_OE(tx_clk_oe),
      .TXD_IN(txd_in), .TXD_OUT(txd_out), .TXD_OE(txd_oe), .TX_CTL_IN(tx_ctl_in),
      .TXW_VALID(txw_valid), .TXW_READY(txw_ready), .TXW_DATA(txw_data),
      .LINK_OVERRUN(link_overrun), .SO_VALID(so_valid), .SO_DATA(so_data), .SO_READY(so_ready)
   );

   mtpm_mac_model #(.SD(SD)) u_mac (
      .ref_clk(ref_clk), .mode(mode), .go(go), .lo(m_lo), .hi(m_hi), .ser_en(ser_en),
      .ser_pat(PAT), .tx_clk(m_clk), .txd(m_txd), .tx_ctl(tx_ctl_in)
   );

   always #50 ref_clk = ~ref_clk;

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         num_errors++;
         end_sim();
      end
   end

   task automatic check(input logic [13:0] seen, input logic [13:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic restart(input logic [2:0] m);
      rstn <= 1'b0;
      mode <= m;
      repeat (5) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (12) @(posedge ref_clk);
   endtask

   // One link clock period of the model; it needs 13 cycles to finish
   task automatic send(input logic [4:0] lo, input logic [4:0] hi);
      go <= 1'b1;
      m_lo <= lo;
      m_hi <= hi;
      @(posedge ref_clk);
      go <= 1'b0;
      repeat (14) @(posedge ref_clk);
   endtask

   task automatic take(output mtpm_word_type w);
      w = 'x;
      for (int i = 0; i < 80; i++) begin
         @(posedge ref_clk);
         if (txw_valid === 1'b1) begin
            w = txw_data;
            txw_ready <= 1'b1;
            @(posedge ref_clk);
            txw_ready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic quiet(output logic seen);
      seen = 1'b0;
      repeat (40) begin
         @(posedge ref_clk);
         if (txw_valid !== 1'b0) seen = 1'b1;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_rgmii();
      mtpm_word_type w;
      restart(MODE_RGMII);
      check({txd_oe, tx_clk_oe, txw_valid, link_overrun, so_ready}, 8'h01);
      send(5'h1A, 5'h00);
      send(5'h05, 5'h00);
      take(w);
      check({w.data[3:0], w.ctl, w.mode}, {4'hA, 1'b1, MODE_RGMII});
      take(w);
      check({w.data[3:0], w.ctl, w.mode}, {4'h5, 1'b0, MODE_RGMII});
      $display("done rgmii");
   endtask

   task automatic t_rmii();
      mtpm_word_type w;
      logic seen;
      restart(MODE_RMII);
      send(5'h1F, 5'h00);
      take(w);
      check({w.data[1:0], w.ctl, w.mode}, {2'h3, 1'b1, MODE_RMII});
      // Enable low: the dibit must be dropped
      send(5'h02, 5'h00);
      quiet(seen);
      check(seen, 1'b0);
      $display("done rmii");
   endtask

   task automatic t_rtbi();
      mtpm_word_type w;
      logic [9:0] cg;
      restart(MODE_RTBI);
      for (int i = 0; i < 2; i++) begin
         cg = (i == 0) ? 10'h2B4 : 10'h14B;
         send(cg[4:0], cg[9:5]);
         take(w);
         check({w.data, w.mode}, {cg, MODE_RTBI});
      end
      $display("done rtbi");
   endtask

   task automatic t_nomode();
      logic seen;
      for (int m = 5; m < 8; m++) begin
         restart(3'(m));
         send(5'h1F, 5'h1F);
         quiet(seen);
         check({seen, txd_oe, tx_clk_oe}, 6'h00);
      end
      $display("done no mode");
   endtask

   // Nine words fit (eight queued plus the output stage); the tenth is lost
   task automatic t_overrun();
      mtpm_word_type w;
      logic seen;
      restart(MODE_RGMII);
      for (int i = 0; i < 10; i++) begin
         check(link_overrun, 1'b0);
         send({1'b0, 4'(i)}, 5'h00);
      end
      check(link_overrun, 1'b1);
      for (int i = 0; i < 9; i++) begin
         take(w);
         check({w.data[3:0], w.mode}, {4'(i), MODE_RGMII});
      end
      quiet(seen);
      check(seen, 1'b0);
      $display("done overrun");
   endtask

   task automatic ser_out(input logic [2:0] m, input logic [3:0] oe, input logic [9:0] v);
      logic [39:0] dh;
      logic [39:0] ch;
      logic [9:0] dec;
      logic bad;
      logic hit;
      dh = '0;
      ch = '0;
      bad = 1'b0;
      hit = 1'b0;
      restart(m);
      so_valid <= 1'b1;
      so_data <= v;
      @(posedge ref_clk);
      so_valid <= 1'b0;
      @(posedge ref_clk);
      check(so_ready, 1'b0);
      for (int i = 0; i < 400 && !hit; i++) begin
         @(posedge ref_clk);
         dh = {dh[38:0], txd_out[2]};
         ch = {ch[38:0], tx_clk_out};
         if (txd_out[1] !== ~txd_out[2] || txd_oe !== oe) bad = 1'b1;
         if (m == MODE_SGMII && txd_out[3] !== ~tx_clk_out) bad = 1'b1;
         // One sample per bit, oldest sample is the first bit sent
         for (int k = 0; k < 10; k++) dec[k] = dh[SD * (9 - k)];
         hit = (dec === v);
      end
      check({hit, bad}, 2'h2);
      if (m == MODE_SGMII) begin
         check({tx_clk_oe, ch[0] ^ ch[SD]}, 2'h3);
      end else begin
         check({tx_clk_oe, tx_clk_out}, 2'h0);
      end
      $display("done serial out");
   endtask

   // Word boundaries are not aligned, so any rotation of the pattern is accepted
   task automatic ser_in(input logic [2:0] m);
      mtpm_word_type w;
      logic [19:0] rot;
      logic ok;
      ser_en <= 1'b1;
      restart(m);
      take(w);
      take(w);
      ok = 1'b0;
      for (int r = 0; r < 10; r++) begin
         rot = {PAT, PAT} >> r;
         if (w.data === rot[9:0]) ok = 1'b1;
      end
      check({ok, w.mode}, {1'b1, m});
      ser_en <= 1'b0;
      $display("done serial in");
   endtask

   initial begin
      t_rgmii();
      t_rmii();
      t_rtbi();
      t_nomode();
      t_overrun();
      ser_out(MODE_SGMII, 4'hE, 10'h0F5);
      ser_out(MODE_BASEX, 4'h6, 10'h31A);
      ser_in(MODE_SGMII);
      ser_in(MODE_BASEX);
      end_sim();
   end
endmodule
